// *** logic/sync_burst_sram.sv ***
// Pipelined burst static memory, 65536 words of 64 bits, byte writable.
// Assumes the host drives cmd and data_in on core_clk; oe, snooze and mode are pins.
module sync_burst_sram (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire burst_sram_pkg::host_cmd_t cmd,
  input wire logic [burst_sram_pkg::DATA_W-1:0] data_in,
  input wire logic output_enable_n,
  input wire logic snooze_request,
  input wire logic burst_order_sel,
  output logic [burst_sram_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  output logic standby
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic is_selected(input burst_sram_pkg::host_cmd_t c);
    return !c.chip_select_n && !c.second_select_n && c.second_select
      && !c.third_select_n && c.third_select;
  endfunction : is_selected

  function automatic logic [burst_sram_pkg::LANES-1:0] write_lanes(
    input burst_sram_pkg::host_cmd_t c);
    if (!c.full_word_write_n) begin
      return burst_sram_pkg::LANES_ALL;
    end else if (!c.byte_write_gate_n) begin
      return ~c.byte_lane_write_n;
    end else begin
      return burst_sram_pkg::LANES_NONE;
    end
  endfunction : write_lanes

  function automatic logic [burst_sram_pkg::BEAT_W-1:0] burst_low(
    input logic [burst_sram_pkg::BEAT_W-1:0] start,
    input logic [burst_sram_pkg::BEAT_W-1:0] beat,
    input logic interleave);
    if (interleave) begin
      return start ^ beat;
    end else begin
      return start + beat;
    end
  endfunction : burst_low

  function automatic logic [burst_sram_pkg::DATA_W-1:0] merge(
    input logic [burst_sram_pkg::DATA_W-1:0] old_word,
    input logic [burst_sram_pkg::DATA_W-1:0] new_word,
    input logic [burst_sram_pkg::LANES-1:0] mask);
    logic [burst_sram_pkg::DATA_W-1:0] w;
    w = old_word;
    for (int i = 0; i < burst_sram_pkg::LANES; i++) begin
      if (mask[i]) begin
        w[i*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W] =
          new_word[i*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W];
      end
    end
    return w;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // The pin controls act two edges late; a fully asynchronous path would need
  // output logic outside this clocked core.

  logic [burst_sram_pkg::SYNC_STAGES-1:0] oe_sync;
  logic [burst_sram_pkg::SYNC_STAGES-1:0] zz_sync;
  logic [burst_sram_pkg::SYNC_STAGES-1:0] mode_sync;
  logic oe_on;
  logic zz;
  logic interleave;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      oe_sync <= burst_sram_pkg::SYNC_HIGH;
      zz_sync <= burst_sram_pkg::SYNC_LOW;
      mode_sync <= burst_sram_pkg::SYNC_HIGH;
    end else begin
      oe_sync <= {oe_sync[0], output_enable_n};
      zz_sync <= {zz_sync[0], snooze_request};
      mode_sync <= {mode_sync[0], burst_order_sel};
    end
  end

  assign oe_on = !oe_sync[1];
  assign zz = zz_sync[1];
  assign interleave = mode_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Input register

  burst_sram_pkg::host_cmd_t cmd_q;
  logic [burst_sram_pkg::DATA_W-1:0] din_q;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cmd_q <= burst_sram_pkg::CMD_IDLE;
      din_q <= burst_sram_pkg::DATA_RST;
    end else begin
      cmd_q <= cmd;
      din_q <= data_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  logic load_p;
  logic load_c;
  logic sel_all;
  logic wr_req;
  logic lane_off;
  logic [burst_sram_pkg::LANES-1:0] lane_mask;

  always_comb begin
    sel_all = is_selected(cmd_q);
    load_p = !cmd_q.proc_addr_strobe_n && !cmd_q.chip_select_n;
    load_c = !cmd_q.ctrl_addr_strobe_n && !load_p;
    lane_mask = write_lanes(cmd_q);
    wr_req = |lane_mask;
    lane_off = !cmd_q.byte_write_gate_n && !(&cmd_q.byte_lane_write_n);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst state

  logic active;
  logic [burst_sram_pkg::ADDR_W-1:0] base_addr;
  logic [burst_sram_pkg::BEAT_W-1:0] beat;
  logic next_active;
  logic [burst_sram_pkg::ADDR_W-1:0] next_base;
  logic [burst_sram_pkg::BEAT_W-1:0] next_beat;
  burst_sram_pkg::op_t next_op;
  logic [burst_sram_pkg::ADDR_W-1:0] acc_addr;

  always_comb begin
    next_active = active;
    next_base = base_addr;
    next_beat = beat;
    next_op = burst_sram_pkg::OP_IDLE;
    if (zz) begin
      next_active = 1'b0;
    end else if (load_p || load_c) begin
      next_base = cmd_q.addr_in;
      next_beat = burst_sram_pkg::BEAT_RST;
      next_active = sel_all;
      if (sel_all && load_c && wr_req) begin
        next_op = burst_sram_pkg::OP_WRITE;
      end else if (sel_all) begin
        next_op = burst_sram_pkg::OP_READ;
      end
    end else if (active) begin
      if (!cmd_q.burst_step_n) begin
        next_beat = beat + burst_sram_pkg::BEAT_ONE;
      end
      if (wr_req) begin
        next_op = burst_sram_pkg::OP_WRITE;
      end else begin
        next_op = burst_sram_pkg::OP_READ;
      end
    end
    // Upper bits stay as loaded; only the low pair follows the counter
    acc_addr = {next_base[burst_sram_pkg::ADDR_W-1:burst_sram_pkg::BEAT_W],
      burst_low(next_base[burst_sram_pkg::BEAT_W-1:0], next_beat, interleave)};
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      active <= 1'b0;
      base_addr <= burst_sram_pkg::ADDR_RST;
      beat <= burst_sram_pkg::BEAT_RST;
    end else begin
      active <= next_active;
      base_addr <= next_base;
      beat <= next_beat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Self-timed write stage
  // The array write lands one edge after the command, so reads of the same
  // word in that window are served from this stage.

  logic wr_pend;
  logic [burst_sram_pkg::ADDR_W-1:0] wr_addr;
  logic [burst_sram_pkg::DATA_W-1:0] wr_data;
  logic [burst_sram_pkg::LANES-1:0] wr_mask;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wr_pend <= 1'b0;
      wr_addr <= burst_sram_pkg::ADDR_RST;
      wr_data <= burst_sram_pkg::DATA_RST;
      wr_mask <= burst_sram_pkg::LANES_NONE;
    end else begin
      wr_pend <= (next_op == burst_sram_pkg::OP_WRITE);
      wr_addr <= acc_addr;
      wr_data <= din_q;
      wr_mask <= lane_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array, no reset so contents survive snooze

  logic [burst_sram_pkg::DATA_W-1:0] mem [burst_sram_pkg::WORDS];
  logic [burst_sram_pkg::DATA_W-1:0] rd_raw;

  always_ff @(posedge core_clk) begin
    if (wr_pend) begin
      for (int i = 0; i < burst_sram_pkg::LANES; i++) begin
        if (wr_mask[i]) begin
          mem[wr_addr][i*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W] <=
            wr_data[i*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W];
        end
      end
    end
    rd_raw <= mem[acc_addr];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read stage with pass-through

  logic rd_valid;
  logic [burst_sram_pkg::DATA_W-1:0] byp_data;
  logic [burst_sram_pkg::LANES-1:0] byp_mask;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rd_valid <= 1'b0;
      byp_data <= burst_sram_pkg::DATA_RST;
      byp_mask <= burst_sram_pkg::LANES_NONE;
    end else begin
      rd_valid <= (next_op == burst_sram_pkg::OP_READ);
      byp_data <= wr_data;
      if (wr_pend && wr_addr == acc_addr) begin
        byp_mask <= wr_mask;
      end else begin
        byp_mask <= burst_sram_pkg::LANES_NONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output register

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      data_out <= burst_sram_pkg::DATA_RST;
      data_oe <= 1'b0;
      standby <= 1'b0;
    end else begin
      if (rd_valid) begin
        data_out <= merge(rd_raw, byp_data, byp_mask);
      end
      data_oe <= rd_valid && oe_on && !zz && !lane_off;
      standby <= zz;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  property p_deselect;
    (load_p || load_c) && !sel_all |=> !active ##1 !data_oe;
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselect load left device active");

  property p_load_addr;
    (load_p || load_c) && !zz |=> base_addr == $past(cmd_q.addr_in) && beat == 2'h0;
  endproperty
  a_load_addr: assert property (p_load_addr) else $error("address not loaded on strobe");

  property p_ignore_selects;
    active && !load_p && !load_c && !zz && !sel_all |=> active;
  endproperty
  a_ignore_selects: assert property (p_ignore_selects) else $error("selects sampled in burst");

  property p_wait_hold;
    active && !load_p && !load_c && !zz && cmd_q.burst_step_n |=> $stable(beat);
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("counter moved on wait");

  property p_step;
    active && !load_p && !load_c && !zz && !cmd_q.burst_step_n
      |=> beat == $past(beat) + 2'h1;
  endproperty
  a_step: assert property (p_step) else $error("counter did not step");

  property p_proc_read;
    load_p && sel_all && !zz |=> !wr_pend && rd_valid;
  endproperty
  a_proc_read: assert property (p_proc_read) else $error("processor start wrote");

  property p_gate;
    cmd_q.full_word_write_n && cmd_q.byte_write_gate_n && active && !zz
      && !load_p && !load_c |=> !wr_pend;
  endproperty
  a_gate: assert property (p_gate) else $error("write without gate");

  property p_global;
    !cmd_q.full_word_write_n && active && !zz && !load_p && !load_c
      |=> wr_pend && wr_mask == 8'hff;
  endproperty
  a_global: assert property (p_global) else $error("full word write not full");

  property p_hiz;
    lane_off |=> !data_oe;
  endproperty
  a_hiz: assert property (p_hiz) else $error("outputs on during lane write");

  property p_first_word;
    load_p && sel_all && !zz ##1 (oe_on && !zz && !lane_off) |=> data_oe;
  endproperty
  a_first_word: assert property (p_first_word) else $error("first word not on third edge");

  sequence s_wr_rd;
    (next_op == burst_sram_pkg::OP_WRITE && &lane_mask)
      ##1 (next_op == burst_sram_pkg::OP_READ && acc_addr == $past(acc_addr));
  endsequence

  property p_passthru;
    s_wr_rd |=> ##1 data_out == $past(din_q, 3);
  endproperty
  a_passthru: assert property (p_passthru) else $error("written data not passed through");

  property p_snooze;
    zz |=> !data_oe && !active && standby;
  endproperty
  a_snooze: assert property (p_snooze) else $error("snooze left outputs on");

  c_passthru: cover property (s_wr_rd);
  c_burst4: cover property (load_p && sel_all ##1 (!cmd_q.burst_step_n && active) [*3]);
  c_ctrl_write: cover property (load_c && sel_all && wr_req);
  c_linear: cover property (!interleave && active && !cmd_q.burst_step_n);

endmodule : sync_burst_sram

// *** logic/burst_sram_pkg.sv ***
// Shared widths, reset values and carrier types for the burst static memory.
// Assumes one core clock; host logic drives the command fields on that clock.
package burst_sram_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Array shape
  localparam int ADDR_W = 16;
  localparam int DATA_W = 64;
  localparam int LANES = 8;
  localparam int LANE_W = 8;
  localparam int BEAT_W = 2;
  localparam int WORDS = 65536;

  ////////////////////////////////////////////////////////////////////////////
  // Timing and reset values
  localparam int CLK_PERIOD_NS = 10;
  localparam int FIRST_WORD_CYCLES = 3;
  localparam int SYNC_STAGES = 2;
  localparam logic [BEAT_W-1:0] BEAT_RST = 2'h0;
  localparam logic [BEAT_W-1:0] BEAT_ONE = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 64'h0000_0000_0000_0000;
  localparam logic [LANES-1:0] LANES_NONE = 8'h00;
  localparam logic [LANES-1:0] LANES_ALL = 8'hff;
  localparam logic [SYNC_STAGES-1:0] SYNC_HIGH = 2'h3;
  localparam logic [SYNC_STAGES-1:0] SYNC_LOW = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_READ = 2'b01,
    OP_WRITE = 2'b10
  } op_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr_in;
    logic proc_addr_strobe_n;
    logic ctrl_addr_strobe_n;
    logic burst_step_n;
    logic chip_select_n;
    logic second_select_n;
    logic second_select;
    logic third_select_n;
    logic third_select;
    logic [LANES-1:0] byte_lane_write_n;
    logic byte_write_gate_n;
    logic full_word_write_n;
  } host_cmd_t;

  // All strobes and write controls inactive
  localparam host_cmd_t CMD_IDLE = '1;

endpackage : burst_sram_pkg

// *** testbench/host_model.sv ***
// Host side of the burst memory: drives commands, data and pins, notes expected reads.
// Assumes the bench clock; every drive lands on the falling edge.
module host_model (
  input wire logic core_clk,
  output burst_sram_pkg::host_cmd_t cmd,
  output logic [burst_sram_pkg::DATA_W-1:0] data_in,
  output logic output_enable_n,
  output logic snooze_request,
  output logic burst_order_sel
);
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////////////////////////////////////////
  // Expected words carry the cycle they are due in, so latency is checked too
  logic [95:0] exp_q[$];
  logic [63:0] mem[logic [15:0]];
  logic [31:0] seed;
  logic [31:0] cyc;

  initial begin
    cmd = burst_sram_pkg::CMD_IDLE;
    data_in = burst_sram_pkg::DATA_RST;
    output_enable_n = 1'b0;
    snooze_request = 1'b0;
    burst_order_sel = 1'b1;
    seed = 32'h4a52_c285;
    cyc = 32'h0000_0000;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 32'd1;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Idle data lines keep changing so a stale value never looks valid
  function automatic logic [63:0] rnd();
    logic [31:0] hi;
    seed = lfsr(seed);
    hi = seed;
    seed = lfsr(seed);
    return {hi, seed};
  endfunction : rnd

  function automatic burst_sram_pkg::host_cmd_t sel(input logic [15:0] a);
    sel = burst_sram_pkg::CMD_IDLE;
    sel.addr_in = a;
    sel.chip_select_n = 1'b0;
    sel.second_select_n = 1'b0;
    sel.third_select_n = 1'b0;
  endfunction : sel

  task automatic send(input burst_sram_pkg::host_cmd_t c, input logic [63:0] d,
                      input bit rd = 1'b0, input logic [63:0] e = '0);
    @(negedge core_clk);
    cmd <= c;
    data_in <= d;
    if (rd) exp_q.push_back({cyc + 32'd3, e});
  endtask : send

  task automatic pins(input logic oe_n, input logic zz, input logic mode);
    @(negedge core_clk);
    output_enable_n <= oe_n;
    snooze_request <= zz;
    burst_order_sel <= mode;
  endtask : pins

  // Controller strobe with primary select off ends any burst; the other fields except
  // the byte write gate wander at random since a deselect must ignore them all
  task automatic idle(input int n);
    burst_sram_pkg::host_cmd_t c;
    logic [63:0] r;
    repeat (n) begin
      r = rnd();
      c = burst_sram_pkg::CMD_IDLE;
      c.addr_in = r[15:0];
      {c.proc_addr_strobe_n, c.burst_step_n, c.second_select_n, c.second_select} = r[19:16];
      {c.third_select_n, c.third_select, c.full_word_write_n} = r[22:20];
      c.byte_lane_write_n = r[30:23];
      c.ctrl_addr_strobe_n = 1'b0;
      send(c, r);
    end
  endtask : idle

  task automatic write_word(input logic [15:0] a, input logic [63:0] d, input logic [7:0] lanes);
    burst_sram_pkg::host_cmd_t c;
    logic [63:0] w;
    c = sel(a);
    c.ctrl_addr_strobe_n = 1'b0;
    if (lanes == 8'hff) begin
      c.full_word_write_n = 1'b0;
    end else begin
      c.byte_write_gate_n = 1'b0;
      c.byte_lane_write_n = ~lanes;
    end
    w = mem.exists(a) ? mem[a] : burst_sram_pkg::DATA_RST;
    for (int i = 0; i < 8; i++) if (lanes[i]) w[8*i +: 8] = d[8*i +: 8];
    mem[a] = w;
    send(c, d);
  endtask : write_word

  task automatic burst(input logic [15:0] a, input bit proc, input int beats, input int hold);
    burst_sram_pkg::host_cmd_t c;
    logic [63:0] r;
    logic [1:0] lo;
    c = sel(a);
    lo = a[1:0];
    if (proc) c.proc_addr_strobe_n = 1'b0;
    else c.ctrl_addr_strobe_n = 1'b0;
    send(c, rnd(), 1'b1, mem[a]);
    for (int k = 1; k < beats; k++) begin
      r = rnd();
      c = burst_sram_pkg::CMD_IDLE;
      c.addr_in = r[15:0];
      {c.chip_select_n, c.second_select, c.third_select} = r[18:16];
      if (k == hold) send(c, r, 1'b1, mem[{a[15:2], lo}]);
      c.burst_step_n = 1'b0;
      lo = burst_order_sel ? a[1:0] ^ k[1:0] : a[1:0] + k[1:0];
      send(c, r, 1'b1, mem[{a[15:2], lo}]);
    end
  endtask : burst

endmodule : host_model

// *** testbench/sync_burst_sram_64k_x64_tb_top.sv ***
// Self-checking bench for the burst memory with a host model driving it.
// Assumes the package and design files are compiled first.
module sync_burst_sram_64k_x64_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic core_clk;
  logic reset_n;
  burst_sram_pkg::host_cmd_t cmd;
  logic [burst_sram_pkg::DATA_W-1:0] data_in;
  logic [burst_sram_pkg::DATA_W-1:0] data_out;
  logic output_enable_n;
  logic snooze_request;
  logic burst_order_sel;
  logic data_oe;
  logic standby;
  int errors = 0;
  int checked = 0;
  int cycles = 0;

  sync_burst_sram i_sync_burst_sram (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .cmd(cmd),
    .data_in(data_in),
    .output_enable_n(output_enable_n),
    .snooze_request(snooze_request),
    .burst_order_sel(burst_order_sel),
    .data_out(data_out),
    .data_oe(data_oe),
    .standby(standby)
  );

  host_model i_host_model (
    .core_clk(core_clk),
    .cmd(cmd),
    .data_in(data_in),
    .output_enable_n(output_enable_n),
    .snooze_request(snooze_request),
    .burst_order_sel(burst_order_sel)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    if (errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // A hang counts as a mismatch
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      stop_test();
    end
  end

  // Every driven output word must match the oldest note, in its due cycle
  always @(posedge core_clk) begin
    #1;
    if (data_oe === 1'b1) begin
      if (i_host_model.exp_q.size() == 0) check({95'h0, data_oe}, 96'h0);
      else check({i_host_model.cyc, data_out}, i_host_model.exp_q.pop_front());
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    burst_sram_pkg::host_cmd_t c;
    reset_n = 1'b0;
    repeat (6) @(negedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    #1;
    check({31'h0, data_oe, data_out}, {32'h0, burst_sram_pkg::DATA_RST});
    for (int i = 0; i < 4; i++) i_host_model.write_word(16'hfffc + i[15:0], i_host_model.rnd(), 8'hff);
    for (int m = 0; m < 2; m++) begin
      i_host_model.pins(1'b0, 1'b0, m[0]);
      i_host_model.idle(4);
      for (int s = 0; s < 4; s++) begin
        i_host_model.burst(16'hfffc + s[15:0], s[0], 4, s);
        i_host_model.idle(1);
      end
    end
    // Lane write, then a gated-off lane request that must read back at once
    for (int i = 0; i < 8; i++) begin
      i_host_model.write_word(16'hfffd, i_host_model.rnd(), 8'h01 << i);
      c = i_host_model.sel(16'hfffd);
      c.ctrl_addr_strobe_n = 1'b0;
      c.byte_lane_write_n = ~(8'h01 << i);
      i_host_model.send(c, i_host_model.rnd(), 1'b1, i_host_model.mem[16'hfffd]);
      i_host_model.idle(1);
    end
    // Processor start turned into a write on the following wait cycle
    c = i_host_model.sel(16'h1234);
    c.proc_addr_strobe_n = 1'b0;
    i_host_model.send(c, i_host_model.rnd());
    c = burst_sram_pkg::CMD_IDLE;
    c.byte_write_gate_n = 1'b0;
    c.byte_lane_write_n = burst_sram_pkg::LANES_NONE;
    i_host_model.mem[16'h1234] = 64'h0123_4567_89ab_cdef;
    i_host_model.send(c, 64'h0123_4567_89ab_cdef);
    i_host_model.idle(2);
    i_host_model.burst(16'h1234, 1'b1, 1, 0);
    // Processor start read, full word write on the wait cycle, then read it back
    c = i_host_model.sel(16'h1234);
    c.proc_addr_strobe_n = 1'b0;
    i_host_model.send(c, i_host_model.rnd(), 1'b1, i_host_model.mem[16'h1234]);
    c = burst_sram_pkg::CMD_IDLE;
    c.full_word_write_n = 1'b0;
    i_host_model.mem[16'h1234] = 64'hfedc_ba98_7654_3210;
    i_host_model.send(c, 64'hfedc_ba98_7654_3210);
    c = i_host_model.sel(16'h1234);
    c.ctrl_addr_strobe_n = 1'b0;
    i_host_model.send(c, i_host_model.rnd(), 1'b1, i_host_model.mem[16'h1234]);
    // One select off at a time: no output and no write
    for (int s = 0; s < 5; s++) begin
      c = i_host_model.sel(16'h1234);
      c.ctrl_addr_strobe_n = 1'b0;
      c.full_word_write_n = 1'b0;
      {c.chip_select_n, c.second_select_n, c.second_select, c.third_select_n, c.third_select} =
        5'b00101 ^ (5'b10000 >> s);
      i_host_model.send(c, i_host_model.rnd());
      i_host_model.idle(2);
    end
    c = i_host_model.sel(16'h1234);
    c.chip_select_n = 1'b1;
    c.proc_addr_strobe_n = 1'b0;
    i_host_model.send(c, i_host_model.rnd());
    i_host_model.idle(4);
    i_host_model.burst(16'h1234, 1'b0, 1, 0);
    // Snooze and output enable both keep the bus quiet
    i_host_model.pins(1'b0, 1'b1, 1'b1);
    i_host_model.idle(4);
    check({95'h0, standby}, {95'h0, 1'b1});
    c = i_host_model.sel(16'h1234);
    c.proc_addr_strobe_n = 1'b0;
    i_host_model.send(c, i_host_model.rnd());
    i_host_model.idle(4);
    i_host_model.pins(1'b1, 1'b0, 1'b1);
    i_host_model.idle(4);
    i_host_model.send(c, i_host_model.rnd());
    i_host_model.idle(4);
    i_host_model.pins(1'b0, 1'b0, 1'b1);
    i_host_model.idle(4);
    check({95'h0, standby}, 96'h0);
    i_host_model.burst(16'h1234, 1'b1, 1, 0);
    i_host_model.idle(6);
    check({64'h0, 32'(i_host_model.exp_q.size())}, 96'h0);
    stop_test();
  end

endmodule : sync_burst_sram_64k_x64_tb_top
